// ---- verilog/glh_core.sv ----
// listener and talker handshake engine with serial and parallel poll, ahb-lite registers
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
//
// Contract
// - normal mode: byte sets request, rfd false until read
// - hold-all mode: rfd false until finish command
// - while held, no data byte taken (commands still taken under atn), data stable
// - hold-end mode: only end bytes held off
// - continuous mode: rfd auto, end bytes held
// - eos byte sent like any data byte
// - send eoi command marks next written byte
// - auto end on matching outgoing eos byte
// - end bit on matching received eos byte
// - end bit on byte received with eoi
// - eoi level latched with each data byte
// - srq with rsv, held false during spas
// - pending flag set with rsv, cleared by poll
// - status byte sent once per poll
// - optional end with the status byte
// - poll bit on chosen line and polarity
// - remote config from enable and disable commands
// - poll register: line, sense, disable bits
module glh_core
  import glh_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic [7:0] dio_in,
  input wire logic dav_in,
  input wire logic rfd_in,
  input wire logic dac_in,
  input wire logic eoi_in,
  input wire logic atn_in,
  output logic [7:0] dio_out,
  output logic [7:0] dio_oe_out,
  output logic eoi_out,
  output logic eoi_oe_out,
  output logic dav_out,
  output logic rfd_out,
  output logic dac_out,
  output logic srq_out
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [7:0] line_mask(input logic [2:0] l);
    line_mask = 8'h01 << l;
  endfunction

  logic [SYNC_W-1:0] sync1, sync2;
  logic [7:0] s_dio;
  logic s_dav, s_rfd, s_dac, s_eoi, s_atn;
  logic dp_write;
  logic [7:0] dp_addr;
  logic [MODE_W-1:0] mode_reg;
  logic [7:0] eos_reg, spoll_reg, data_in, tx_byte, sh_byte;
  logic [PP_W-1:0] ppoll_reg;
  logic [3:0] pp_rem;
  logic data_in_request, data_out_request, end_status, eoi_status, service_pending;
  logic holdoff, spms, ppc_armed, pp_rem_en, tx_pending, tx_end, send_eoi_armed;
  logic stb_sent, spas_prev, rdy_prev, sh_eoi, sh_is_stb;
  logic rx_match, tx_match;
  logic [31:0] next_rdata;
  logic [7:0] next_dio, next_dio_oe;
  logic next_eoi_oe;
  glh_ah_state_t ah_state;
  glh_sh_state_t sh_state;
  glh_hs_mode_t hs_mode;

  // two-stage pin synchroniser
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sync1 <= 13'h0000;
      sync2 <= 13'h0000;
    end else if (ce_in) begin
      sync1 <= {dio_in, dav_in, rfd_in, dac_in, eoi_in, atn_in};
      sync2 <= sync1;
    end
  end
  assign {s_dio, s_dav, s_rfd, s_dac, s_eoi, s_atn} = sync2;

  // host bus phases
  wire bus_take = hsel_in && htrans_in[1] && hready_in;
  wire rd_take = bus_take && !hwrite_in;
  wire rd_data_in = rd_take && hit(haddr_in[7:0], OFS_DATA);
  wire rd_status = rd_take && hit(haddr_in[7:0], OFS_STATUS);
  wire wr_byte_out = dp_write && hit(dp_addr, OFS_DATA);
  wire wr_mode = dp_write && hit(dp_addr, OFS_MODE);
  wire wr_eos = dp_write && hit(dp_addr, OFS_EOS);
  wire wr_spoll = dp_write && hit(dp_addr, OFS_SPOLL);
  wire wr_ppoll = dp_write && hit(dp_addr, OFS_PPOLL);
  wire wr_aux = dp_write && hit(dp_addr, OFS_AUX);
  wire aux_finish = wr_aux && (hwdata_in[7:0] == AUX_FINISH);
  wire aux_send_eoi = wr_aux && (hwdata_in[7:0] == AUX_SEND_EOI);
  assign hreadyout_out = ce_in;
  assign hresp_out = 1'b0;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata_out <= 32'h0000_0000;
    end else if (ce_in) begin
      dp_write <= bus_take && hwrite_in;
      dp_addr <= haddr_in[7:0];
      hrdata_out <= rd_take ? next_rdata : 32'h0000_0000;
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      mode_reg <= MODE_RST;
      eos_reg <= EOS_RST;
      ppoll_reg <= PPOLL_RST;
    end else if (ce_in) begin
      if (wr_mode) mode_reg <= hwdata_in[MODE_W-1:0];
      if (wr_eos) eos_reg <= hwdata_in[7:0];
      if (wr_ppoll) ppoll_reg <= hwdata_in[PP_W-1:0];
    end
  end
  assign hs_mode = glh_hs_mode_t'(mode_reg[MODE_HS_LO +: 2]);
  wire listen_en = mode_reg[MODE_LISTEN];
  wire talk_en = mode_reg[MODE_TALK];

  glh_eos_match u_rx_match (
    .byte_in(s_dio),
    .eos_in(eos_reg),
    .width8_in(mode_reg[MODE_EOS_W8]),
    .match_out(rx_match)
  );
  glh_eos_match u_tx_match (
    .byte_in(hwdata_in[7:0]),
    .eos_in(eos_reg),
    .width8_in(mode_reg[MODE_EOS_W8]),
    .match_out(tx_match)
  );

  // acceptor handshake
  wire listening = s_atn || listen_en;
  wire wait_read = (hs_mode == GLH_HS_NORMAL) || (hs_mode == GLH_HS_HOLD_END);
  wire rfd_block = !s_atn && (holdoff || (wait_read && data_in_request));
  wire rfd_now = (ah_state == AH_READY) && !rfd_block;
  wire ah_take = listening && rfd_now && s_dav;
  wire take_data = ah_take && !s_atn;
  wire take_cmd = ah_take && s_atn;
  wire rx_end = s_eoi || (mode_reg[MODE_END_EOS] && rx_match);
  wire hold_this = (hs_mode == GLH_HS_HOLD_ALL) || ((hs_mode[1]) && rx_end);
  wire [6:0] cmd = s_dio[6:0];
  assign rfd_out = !listening || rfd_now;
  assign dac_out = !listening || (ah_state == AH_DONE);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ah_state <= AH_READY;
    end else if (ce_in) begin
      unique case (ah_state)
        AH_READY: if (ah_take) ah_state <= AH_ACCEPT;
        AH_ACCEPT: ah_state <= AH_DONE;
        AH_DONE: if (!s_dav) ah_state <= AH_READY;
        default: ah_state <= AH_READY;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      data_in <= 8'h00;
      eoi_status <= 1'b0;
    end else if (ce_in && take_data) begin
      data_in <= s_dio;
      eoi_status <= s_eoi;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      data_in_request <= 1'b0;
      end_status <= 1'b0;
      holdoff <= 1'b0;
    end else if (ce_in) begin
      if (take_data) data_in_request <= 1'b1;
      else if (rd_data_in) data_in_request <= 1'b0;
      if (take_data && rx_end) end_status <= 1'b1;
      else if (rd_status) end_status <= 1'b0;
      if (take_data && hold_this) holdoff <= 1'b1;
      else if (aux_finish && holdoff) holdoff <= 1'b0;
    end
  end

  // bus command decode under attention
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      spms <= 1'b0;
      ppc_armed <= 1'b0;
      pp_rem_en <= 1'b0;
      pp_rem <= 4'h0;
    end else if (ce_in && take_cmd) begin
      if (cmd == CMD_SPE) spms <= 1'b1;
      if (cmd == CMD_SPD) spms <= 1'b0;
      if (cmd[6:5] != CMD_SEC_HI) ppc_armed <= (cmd == CMD_PPC) && listen_en;
      if (cmd == CMD_PPU || (ppc_armed && cmd[6:4] == CMD_PPD_HI)) begin
        pp_rem_en <= 1'b0;
      end else if (ppc_armed && cmd[6:4] == CMD_PPE_HI) begin
        pp_rem <= cmd[3:0];
        pp_rem_en <= 1'b1;
      end
    end
  end

  // source handshake and byte-out path
  wire tacs = talk_en && !s_atn && !spms;
  wire spas = talk_en && spms && !s_atn;
  wire spas_fall = spas_prev && !spas;
  wire start_stb = spas && !stb_sent && (sh_state == SH_IDLE);
  wire start_data = tacs && tx_pending && (sh_state == SH_IDLE);
  wire sh_finish = (sh_state == SH_DAV) && s_dac && !s_atn;
  wire ready_for_byte = tacs && !tx_pending && (sh_state == SH_IDLE);
  assign dav_out = (sh_state == SH_DAV);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sh_state <= SH_IDLE;
      sh_byte <= 8'h00;
      sh_eoi <= 1'b0;
      sh_is_stb <= 1'b0;
    end else if (ce_in) begin
      if (s_atn) begin
        sh_state <= SH_IDLE;
      end else begin
        unique case (sh_state)
          SH_IDLE: if (start_stb || start_data) begin
            sh_state <= SH_SETTLE;
            sh_byte <= start_stb ? spoll_reg : tx_byte;
            sh_eoi <= start_stb ? mode_reg[MODE_END_STB] : tx_end;
            sh_is_stb <= start_stb;
          end
          SH_SETTLE: if (s_rfd && !s_dac) sh_state <= SH_DAV;
          SH_DAV: if (s_dac) sh_state <= SH_IDLE;
          default: sh_state <= SH_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tx_byte <= 8'h00;
      tx_end <= 1'b0;
      tx_pending <= 1'b0;
      send_eoi_armed <= 1'b0;
      data_out_request <= 1'b0;
      rdy_prev <= 1'b0;
    end else if (ce_in) begin
      rdy_prev <= ready_for_byte;
      if (wr_byte_out) begin
        tx_byte <= hwdata_in[7:0];
        tx_end <= send_eoi_armed || (mode_reg[MODE_EOI_EOS] && tx_match);
      end
      if (wr_byte_out) tx_pending <= 1'b1;
      else if (sh_finish && !sh_is_stb) tx_pending <= 1'b0;
      if (aux_send_eoi) send_eoi_armed <= 1'b1;
      else if (wr_byte_out) send_eoi_armed <= 1'b0;
      if (ready_for_byte && !rdy_prev) data_out_request <= 1'b1;
      else if (rd_status || wr_byte_out) data_out_request <= 1'b0;
    end
  end

  // serial poll: request, pending flag, status byte once
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      spoll_reg <= SPOLL_RST;
      service_pending <= 1'b0;
      stb_sent <= 1'b0;
      spas_prev <= 1'b0;
      srq_out <= 1'b0;
    end else if (ce_in) begin
      spas_prev <= spas;
      srq_out <= spoll_reg[RSV_BIT] && !spas && !(spas_fall && stb_sent);
      if (start_stb) stb_sent <= 1'b1;
      else if (s_atn) stb_sent <= 1'b0;
      if (wr_spoll) spoll_reg <= hwdata_in[7:0];
      else if (spas_fall && stb_sent) spoll_reg[RSV_BIT] <= 1'b0;
      if (wr_spoll && hwdata_in[RSV_BIT]) service_pending <= 1'b1;
      else if (wr_spoll && !spas) service_pending <= 1'b0;
      else if (spas_fall && stb_sent) service_pending <= 1'b0;
    end
  end

  // parallel poll response and pin drivers
  wire pp_local = mode_reg[MODE_PP_LOCAL];
  wire pp_en = pp_local ? !ppoll_reg[PP_DISABLE] : pp_rem_en;
  wire [2:0] pp_line = pp_local ? ppoll_reg[PP_LINE_LO +: 3] : pp_rem[2:0];
  wire pp_sense = pp_local ? ppoll_reg[PP_SENSE] : pp_rem[3];
  wire ist = mode_reg[MODE_IST_SRQ] ? srq_out : mode_reg[MODE_PP_FLAG];
  wire ppr_drive = s_atn && s_eoi && pp_en && (ist == pp_sense);

  always_comb begin
    next_dio = 8'h00;
    next_dio_oe = 8'h00;
    next_eoi_oe = 1'b0;
    if (sh_state != SH_IDLE && !s_atn) begin
      next_dio = sh_byte;
      next_dio_oe = sh_byte;
      next_eoi_oe = sh_eoi;
    end else if (ppr_drive) begin
      next_dio = line_mask(pp_line);
      next_dio_oe = line_mask(pp_line);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      dio_out <= 8'h00;
      dio_oe_out <= 8'h00;
      eoi_oe_out <= 1'b0;
    end else if (ce_in) begin
      dio_out <= next_dio;
      dio_oe_out <= next_dio_oe;
      eoi_oe_out <= next_eoi_oe;
    end
  end
  assign eoi_out = 1'b1;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr_in[7:0])
      OFS_DATA: next_rdata[7:0] = data_in;
      OFS_STATUS: next_rdata[7:0] = {listening, holdoff, spas, service_pending,
                                     eoi_status, end_status, data_out_request, data_in_request};
      OFS_MODE: next_rdata[MODE_W-1:0] = mode_reg;
      OFS_EOS: next_rdata[7:0] = eos_reg;
      OFS_SPOLL: next_rdata[7:0] = spoll_reg;
      OFS_PPOLL: next_rdata[PP_W-1:0] = ppoll_reg;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  normal_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (hs_mode == GLH_HS_NORMAL && data_in_request && listen_en && !s_atn) |-> !rfd_out)
    else $error("rfd true while data awaits read");
  finish_rel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ce_in && aux_finish && holdoff && !take_data) |=> !holdoff)
    else $error("finish did not release holdoff");
  di_stable_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (holdoff && !s_atn) |=> $stable(data_in))
    else $error("data changed during holdoff");
  end_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ce_in && take_data && s_eoi && hs_mode == GLH_HS_HOLD_END) |=> holdoff ##1 !rfd_out)
    else $error("end byte not held off");
  cont_rfd_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (hs_mode == GLH_HS_CONT && !holdoff && ah_state == AH_READY && listen_en) |-> rfd_out)
    else $error("continuous mode blocked rfd");
  eoi_latch_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ce_in && take_data) |=> (eoi_status == $past(s_eoi)) && (data_in == $past(s_dio)))
    else $error("eoi or data not latched together");
  end_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ce_in && take_data && s_eoi) |=> end_status && data_in_request)
    else $error("end bit missed on eoi byte");
  srq_spas_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ce_in && spas) |=> !srq_out)
    else $error("srq asserted in serial poll");
  service_pending_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ce_in && wr_spoll && hwdata_in[RSV_BIT]) |=> service_pending && spoll_reg[RSV_BIT])
    else $error("pending not set with rsv");
  stb_once_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ce_in && start_stb) |=> stb_sent && !start_stb)
    else $error("status byte started twice");
endmodule // glh_core

// ---- verilog/glh_pkg.sv ----
// constants and types for the bus listener and talker handshake engine
package glh_pkg;
  // register byte offsets on the host bus
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_EOS = 8'h0c;
  localparam logic [7:0] OFS_SPOLL = 8'h10;
  localparam logic [7:0] OFS_PPOLL = 8'h14;
  localparam logic [7:0] OFS_AUX = 8'h18;
  // auxiliary command codes
  localparam logic [7:0] AUX_FINISH = 8'h03;
  localparam logic [7:0] AUX_SEND_EOI = 8'h06;
  // mode register fields
  localparam int MODE_W = 11;
  localparam int MODE_HS_LO = 0;
  localparam int MODE_END_EOS = 2;
  localparam int MODE_EOI_EOS = 3;
  localparam int MODE_EOS_W8 = 4;
  localparam int MODE_END_STB = 5;
  localparam int MODE_IST_SRQ = 6;
  localparam int MODE_PP_FLAG = 7;
  localparam int MODE_LISTEN = 8;
  localparam int MODE_TALK = 9;
  localparam int MODE_PP_LOCAL = 10;
  // parallel poll register fields
  localparam int PP_W = 5;
  localparam int PP_LINE_LO = 0;
  localparam int PP_SENSE = 3;
  localparam int PP_DISABLE = 4;
  // serial poll byte request bit
  localparam int RSV_BIT = 6;
  // reset values
  localparam logic [MODE_W-1:0] MODE_RST = 11'h000;
  localparam logic [7:0] EOS_RST = 8'h00;
  localparam logic [7:0] SPOLL_RST = 8'h00;
  localparam logic [PP_W-1:0] PPOLL_RST = 5'h10;
  // bus commands, seven bits
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_PPC = 7'h05;
  localparam logic [6:0] CMD_PPU = 7'h15;
  localparam logic [1:0] CMD_SEC_HI = 2'h3;
  localparam logic [2:0] CMD_PPE_HI = 3'h6;
  localparam logic [2:0] CMD_PPD_HI = 3'h7;
  // pin synchroniser width
  localparam int SYNC_W = 13;

  typedef enum logic [1:0] {
    GLH_HS_NORMAL = 2'b00,
    GLH_HS_HOLD_ALL = 2'b01,
    GLH_HS_HOLD_END = 2'b10,
    GLH_HS_CONT = 2'b11
  } glh_hs_mode_t;

  typedef enum logic [1:0] {
    AH_READY = 2'b00,
    AH_ACCEPT = 2'b01,
    AH_DONE = 2'b11
  } glh_ah_state_t;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_SETTLE = 2'b01,
    SH_DAV = 2'b11
  } glh_sh_state_t;
endpackage

// ---- verilog/glh_eos_match.sv ----
// end-of-string byte comparator, seven or eight bits wide
`timescale 1ns/1ps
module glh_eos_match (
  input wire logic [7:0] byte_in,
  input wire logic [7:0] eos_in,
  input wire logic width8_in,
  output logic match_out
);
  // bit 7 ignored in seven-bit mode
  assign match_out = (byte_in[6:0] == eos_in[6:0]) && (!width8_in || (byte_in[7] == eos_in[7]));
endmodule // glh_eos_match

// ---- dv/glh_bus_partner.sv ----
// bus talker, controller and acceptor model facing the handshake engine
`timescale 1ns/1ps
module glh_bus_partner (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] dev_dio_in,
  input wire logic [7:0] dev_dio_oe_in,
  input wire logic dev_eoi_in,
  input wire logic dev_eoi_oe_in,
  input wire logic dev_dav_in,
  input wire logic dev_dac_in,
  output logic [7:0] dio_out,
  output logic dav_out,
  output logic rfd_out,
  output logic dac_out,
  output logic eoi_out,
  output logic atn_out
);
  logic [7:0] my_dio;
  logic my_eoi;
  logic [7:0] got_byte;
  logic got_eoi;
  int got_n;
  int stall;
  int cnt;
  // wired lines: a released line reads false
  assign dio_out = my_dio | (dev_dio_in & dev_dio_oe_in);
  assign eoi_out = my_eoi | (dev_eoi_in & dev_eoi_oe_in);
  initial begin
    my_dio = 8'h00;
    my_eoi = 1'b0;
    dav_out = 1'b0;
    atn_out = 1'b0;
    rfd_out = 1'b1;
    dac_out = 1'b0;
    stall = 0;
    got_n = 0;
    cnt = 0;
  end
  // acceptor for bytes the device talks, optionally slow
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rfd_out <= 1'b1;
      dac_out <= 1'b0;
      cnt <= 0;
    end else if (dev_dav_in && !dac_out) begin
      rfd_out <= 1'b0;
      cnt <= cnt + 1;
      if (cnt >= stall) begin
        dac_out <= 1'b1;
        got_byte <= dio_out;
        got_eoi <= eoi_out;
        got_n <= got_n + 1;
        cnt <= 0;
      end
    end else if (!dev_dav_in && dac_out) begin
      dac_out <= 1'b0;
      rfd_out <= 1'b1;
    end
  end
  // talker: settle data, raise dav, hold until accepted or limit
  task automatic send(input logic [7:0] b, input logic e, input logic a, input int lim, output logic ok);
    int n;
    n = 0;
    @(posedge clk_in);
    my_dio <= b;
    my_eoi <= e;
    atn_out <= a;
    repeat (2) @(posedge clk_in);
    dav_out <= 1'b1;
    do @(posedge clk_in); while (dev_dac_in !== 1'b1 && n++ < lim);
    ok = (dev_dac_in === 1'b1);
    dav_out <= 1'b0;
    my_dio <= 8'h00;
    my_eoi <= 1'b0;
    n = 0;
    do @(posedge clk_in); while (ok && dev_dac_in === 1'b1 && n++ < 20);
  endtask
  task automatic lines(input logic a, input logic e);
    @(posedge clk_in);
    atn_out <= a;
    my_eoi <= e;
  endtask
endmodule // glh_bus_partner

// ---- dv/glh_core_tb.sv ----
// self-checking bench for the handshake engine, random and corner traffic
`timescale 1ns/1ps
module glh_core_tb
  import glh_pkg::*;
();
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  logic [7:0] dio_line, dio_o, dio_oe;
  logic dav_l, rfd_l, dac_l, eoi_l, atn_l, eoi_o, eoi_oe, dav_o, rfd_o, dac_o, srq_o;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic [7:0] b;
  logic [1:0] m;
  logic ok;
  int n;
  always #10 sys_clk_in = ~sys_clk_in;
  glh_core u_glh_core (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
    .dio_in(dio_line), .dav_in(dav_l), .rfd_in(rfd_l), .dac_in(dac_l), .eoi_in(eoi_l), .atn_in(atn_l),
    .dio_out(dio_o), .dio_oe_out(dio_oe), .eoi_out(eoi_o), .eoi_oe_out(eoi_oe), .dav_out(dav_o),
    .rfd_out(rfd_o), .dac_out(dac_o), .srq_out(srq_o));
  glh_bus_partner u_glh_bus_partner (.clk_in(sys_clk_in), .rst_n_in(rst_n_in), .dev_dio_in(dio_o),
    .dev_dio_oe_in(dio_oe), .dev_eoi_in(eoi_o), .dev_eoi_oe_in(eoi_oe), .dev_dav_in(dav_o),
    .dev_dac_in(dac_o), .dio_out(dio_line), .dav_out(dav_l), .rfd_out(rfd_l), .dac_out(dac_l),
    .eoi_out(eoi_l), .atn_out(atn_l));
  function automatic logic eos_hit(input logic [7:0] v, input logic [7:0] e, input logic w8);
    return w8 ? (v == e) : (v[6:0] == e[6:0]);
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge sys_clk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdg(input logic [7:0] a);
    bus(1'b0, a, 32'h0, rd);
  endtask
  task automatic tk(input int c);
    repeat (c) @(posedge sys_clk_in);
  endtask
  task automatic rx(input logic [7:0] v, input logic e, input int lim);
    u_glh_bus_partner.send(v, e, 1'b0, lim, ok);
  endtask
  task automatic cmd(input logic [7:0] c);
    u_glh_bus_partner.send(c, 1'b0, 1'b1, 40, ok);
  endtask
  task automatic txc(input logic [7:0] v, input logic e);
    int k;
    k = u_glh_bus_partner.got_n;
    wr(OFS_DATA, 32'(v));
    while (u_glh_bus_partner.got_n == k) tk(1);
    chk("talk byte", 32'({u_glh_bus_partner.got_eoi, u_glh_bus_partner.got_byte}), 32'({e, v}));
    while (dav_o !== 1'b0) tk(1);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    tk(20000);
    fail_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h4664903b));
    tk(20);
    rst_n_in <= 1'b1;
    rdg(OFS_MODE);
    chk("mode reset", rd, 32'h0);
    rdg(OFS_PPOLL);
    chk("ppoll reset", rd, 32'h10);
    wr(8'h1c, 32'hff);
    rdg(8'h1c);
    chk("unmapped", rd, 32'h0);
    $display("test registers done");
    wr(OFS_MODE, 32'h100);
    for (int i = 0; i < 8; i++) begin
      b = 8'($urandom);
      rx(b, 1'b0, 40);
      chk("rfd low", 32'({ok, rfd_o}), 32'h2);
      rdg(OFS_STATUS);
      chk("status", 32'(rd[3:0]), 32'h1);
      rdg(OFS_DATA);
      chk("data", rd, 32'(b));
      tk(3);
      chk("rfd back", 32'(rfd_o), 32'h1);
    end
    rx(8'h5a, 1'b0, 40);
    wr(OFS_AUX, 32'(AUX_FINISH));
    tk(3);
    chk("idle finish", 32'(rfd_o), 32'h0);
    rdg(OFS_DATA);
    $display("test normal done");
    wr(OFS_MODE, 32'h101);
    rx(8'hc3, 1'b0, 40);
    rdg(OFS_DATA);
    rdg(OFS_DATA);
    chk("reread", rd, 32'hc3);
    chk("rfd hold", 32'(rfd_o), 32'h0);
    rx(8'h3c, 1'b0, 30);
    chk("refused", 32'(ok), 32'h0);
    rdg(OFS_DATA);
    chk("kept", rd, 32'hc3);
    wr(OFS_AUX, 32'(AUX_FINISH));
    tk(3);
    chk("released", 32'(rfd_o), 32'h1);
    $display("test hold all done");
    wr(OFS_MODE, 32'h102);
    rx(8'h11, 1'b0, 40);
    rdg(OFS_DATA);
    tk(3);
    chk("plain byte", 32'(rfd_o), 32'h1);
    rx(8'h22, 1'b1, 40);
    rdg(OFS_STATUS);
    chk("end eoi", 32'(rd[3:2]), 32'h3);
    rdg(OFS_DATA);
    tk(3);
    chk("end hold", 32'(rfd_o), 32'h0);
    wr(OFS_AUX, 32'(AUX_FINISH));
    tk(3);
    chk("end release", 32'(rfd_o), 32'h1);
    $display("test hold end done");
    wr(OFS_MODE, 32'h103);
    rx(8'h44, 1'b0, 40);
    rx(8'h55, 1'b0, 40);
    chk("auto rfd", 32'({ok, rfd_o}), 32'h3);
    rx(8'h66, 1'b1, 40);
    rdg(OFS_DATA);
    chk("cont data", rd, 32'h66);
    tk(3);
    chk("cont hold", 32'(rfd_o), 32'h0);
    wr(OFS_AUX, 32'(AUX_FINISH));
    tk(3);
    chk("cont release", 32'(rfd_o), 32'h1);
    rdg(OFS_STATUS);
    $display("test continuous done");
    wr(OFS_EOS, 32'h0a);
    for (int i = 0; i < 8; i++) begin
      m = 2'(i) ^ 2'($urandom);
      b = i[0] ? 8'($urandom) : {1'($urandom), 7'h0a};
      wr(OFS_MODE, 32'h100 | 32'(m[0]) << 2 | 32'(m[1]) << 4);
      rx(b, 1'b0, 40);
      rdg(OFS_STATUS);
      chk("eos end", 32'(rd[2]), 32'(m[0] && eos_hit(b, 8'h0a, m[1])));
      rdg(OFS_DATA);
    end
    $display("test eos receive done");
    wr(OFS_MODE, 32'h200);
    u_glh_bus_partner.stall = 3;
    txc(8'h0a, 1'b0);
    tk(6);
    rdg(OFS_STATUS);
    chk("out request", 32'(rd[1]), 32'h1);
    wr(OFS_AUX, 32'(AUX_SEND_EOI));
    txc(8'h31, 1'b1);
    txc(8'h32, 1'b0);
    wr(OFS_MODE, 32'h208);
    u_glh_bus_partner.stall = 0;
    for (int i = 0; i < 6; i++) begin
      b = i[0] ? 8'($urandom) : {1'($urandom), 7'h0a};
      txc(b, eos_hit(b, 8'h0a, 1'b0));
    end
    $display("test talker done");
    wr(OFS_MODE, 32'h220);
    rdg(OFS_STATUS);
    chk("no service_pending", 32'(rd[4]), 32'h0);
    wr(OFS_SPOLL, 32'h40);
    wr(OFS_SPOLL, 32'h00);
    rdg(OFS_STATUS);
    chk("service_pending withdrawn", 32'(rd[4]), 32'h0);
    wr(OFS_SPOLL, 32'h41);
    tk(3);
    rdg(OFS_STATUS);
    chk("srq service_pending", 32'({srq_o, rd[4]}), 32'h3);
    n = u_glh_bus_partner.got_n;
    cmd({1'b0, CMD_SPE});
    u_glh_bus_partner.lines(1'b0, 1'b0);
    tk(6);
    chk("srq in poll", 32'(srq_o), 32'h0);
    while (u_glh_bus_partner.got_n == n) tk(1);
    chk("status byte", 32'({u_glh_bus_partner.got_eoi, u_glh_bus_partner.got_byte}), 32'h141);
    tk(40);
    chk("once", 32'(u_glh_bus_partner.got_n - n), 32'h1);
    cmd({1'b0, CMD_SPD});
    tk(4);
    rdg(OFS_STATUS);
    chk("service_pending done", 32'({srq_o, rd[4]}), 32'h0);
    $display("test serial poll done");
    wr(OFS_MODE, 32'h480);
    u_glh_bus_partner.lines(1'b1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_PPOLL, 32'h8 | 32'(i));
      tk(3);
      chk("pp line", 32'(dio_oe), 32'h1 << i);
    end
    wr(OFS_PPOLL, 32'h03);
    tk(3);
    chk("pp sense", 32'(dio_oe), 32'h0);
    wr(OFS_PPOLL, 32'h1b);
    tk(3);
    chk("pp disable", 32'(dio_oe), 32'h0);
    wr(OFS_MODE, 32'h180);
    cmd({1'b0, CMD_PPC});
    cmd(8'h6d);
    u_glh_bus_partner.lines(1'b1, 1'b1);
    tk(5);
    chk("remote on", 32'(dio_oe), 32'h20);
    u_glh_bus_partner.lines(1'b1, 1'b0);
    tk(5);
    cmd({1'b0, CMD_PPC});
    cmd(8'h70);
    u_glh_bus_partner.lines(1'b1, 1'b1);
    tk(5);
    chk("remote off", 32'(dio_oe), 32'h0);
    u_glh_bus_partner.lines(1'b0, 1'b0);
    $display("test parallel poll done");
    stop_test();
  end
endmodule // glh_core_tb
